/* File: mcit_core.sv */
// fetch, timing and execute core with an apb register slave
`include "mcit_consts.svh"
module mcit_core (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire mcit_pkg::mcit_apb_req_t apb,
  output logic                  [31:0] prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic                  [15:0] code_addr,
  input  wire logic             [7:0]  code_data,
  output logic                         running
);
  import mcit_pkg::*;

  mcit_state_t st_r;
  mcit_state_t st_nxt;
  mcit_dec_t   dec;
  logic [7:0]  op_r;
  logic [7:0]  b1_r;
  logic [15:0] pc_r;
  logic [15:0] pc_nxt;
  logic [15:0] fa_r;
  logic [15:0] fa_nxt;
  logic [7:0]  acc_r;
  logic [7:0]  acc_nxt;
  logic [7:0]  mulb_r;
  logic [7:0]  mulb_nxt;
  logic [7:0]  psw_r;
  logic [7:0]  psw_nxt;
  logic [7:0]  dpl_r;
  logic [7:0]  dpl_nxt;
  logic [7:0]  dph_r;
  logic [7:0]  dph_nxt;
  logic        run_r;
  logic        run_nxt;
  logic        ill_r;
  logic        ill_nxt;
  logic [31:0] prdata_r;
  logic        slverr_r;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic [7:0]  ra_data;
  logic [7:0]  rb_data;
  logic [7:0]  dir_val;
  logic [7:0]  src_val;
  logic [7:0]  old_val;
  logic [7:0]  res;
  logic        cy_nxt;
  logic        cy_upd;

  // parity is live, never stored, so it can not go stale
  function automatic logic [7:0] sfr_rd(input logic [7:0] a);
    case (a)
      `MC_SFR_ACC:  return acc_r;
      `MC_SFR_MULB: return mulb_r;
      `MC_SFR_PSW:  return {psw_r[7:1], ^acc_r};
      `MC_SFR_DPL:  return dpl_r;
      `MC_SFR_DPH:  return dph_r;
      default:      return 8'h00;
    endcase
  endfunction

  // fetch window: code byte k of the instruction is seen in cycle k
  wire       first  = (st_r == ST_C0);
  wire [7:0] cur_op = first ? code_data : op_r;
  wire [7:0] opb1   = (st_r == ST_C1) ? code_data : b1_r;
  wire [7:0] opb2   = code_data;

  mcit_decode u_dec (
    .op  (cur_op),
    .dec (dec)
  );

  wire [1:0] cyc_idx = (st_r == ST_C2) ? 2'd2 :
                       (st_r == ST_C1) ? 2'd1 : 2'd0;
  wire       last    = (cyc_idx == dec.cyc - 2'd1);
  wire       bad_op  = run_r & first & dec.ill;
  wire       issue   = run_r & ~(first & dec.ill);
  wire       retire  = issue & last;

  // apb decode
  wire apb_acc = apb.psel & apb.penable;
  wire apb_set = apb.psel & ~apb.penable;
  wire apb_wr  = apb_acc & apb.pwrite;
  wire ctrl_wr = apb_wr & (apb.paddr == `MC_OFF_CTRL);
  wire pc_wr   = apb_wr & (apb.paddr == `MC_OFF_PC) & ~run_r;
  wire acc_wr  = apb_wr & (apb.paddr == `MC_OFF_ACC);
  wire mulb_wr = apb_wr & (apb.paddr == `MC_OFF_MULB);
  wire psw_wr  = apb_wr & (apb.paddr == `MC_OFF_PSW);

  // operand addressing
  wire       ind     = (dec.src == SRC_IND) | (dec.dst == DST_IND);
  wire [2:0] rsel    = ind ? {2'b00, cur_op[0]} : cur_op[2:0];
  wire [7:0] ra_addr = {3'b000, psw_r[`MC_BANK_HI:`MC_BANK_LO], rsel};
  wire [7:0] rb_addr = (dec.src == SRC_IND) ? ra_data : opb1;
  wire [7:0] imm     = (dec.len == `MC_N3) ? opb2 : opb1;
  wire       dd_mov  = (dec.src == SRC_DIR) & (dec.dst == DST_DIR);
  wire [7:0] dst_adr = dd_mov ? opb2 : opb1;
  wire       wr_dir  = retire & (dec.dst == DST_DIR);
  wire       wr_sfr  = wr_dir & dst_adr[7];
  wire       ram_we  = retire & ((dec.dst == DST_REG)
                     | (dec.dst == DST_IND) | (wr_dir & ~dst_adr[7]));
  wire [7:0] ram_wa  = (dec.dst == DST_REG) ? ra_addr :
                       (dec.dst == DST_IND) ? ra_data : dst_adr;

  mcit_ram u_ram (
    .pclk    (pclk),
    .presetn (presetn),
    .ra_addr (ra_addr),
    .ra_data (ra_data),
    .rb_addr (rb_addr),
    .rb_data (rb_data),
    .we      (ram_we),
    .waddr   (ram_wa),
    .wdata   (res)
  );

  // indirect access reads pointer and data on the two ram ports in one cycle
  always_comb begin
    dir_val = opb1[7] ? sfr_rd(opb1) : rb_data;
  end

  always_comb begin
    case (dec.src)
      SRC_REG: src_val = ra_data;
      SRC_DIR: src_val = dir_val;
      SRC_IND: src_val = rb_data;
      SRC_IMM: src_val = imm;
      default: src_val = acc_r;
    endcase
  end

  // read-modify-write sees the old destination in the same cycle
  always_comb begin
    old_val = (dec.dst == DST_DIR) ? dir_val : acc_r;
  end

  always_comb begin
    res    = src_val;
    cy_nxt = psw_r[`MC_BIT_CY];
    cy_upd = 1'b0;
    case (dec.alu)
      ALU_AND:  res = old_val & src_val;
      ALU_OR:   res = old_val | src_val;
      ALU_XOR:  res = old_val ^ src_val;
      ALU_CLR:  res = 8'h00;
      ALU_CPL:  res = ~acc_r;
      ALU_RL:   res = {acc_r[6:0], acc_r[7]};
      ALU_RR:   res = {acc_r[0], acc_r[7:1]};
      ALU_SWAP: res = {acc_r[3:0], acc_r[7:4]};
      ALU_RLC: begin
        res    = {acc_r[6:0], psw_r[`MC_BIT_CY]};
        cy_nxt = acc_r[7];
        cy_upd = 1'b1;
      end
      ALU_RRC: begin
        res    = {psw_r[`MC_BIT_CY], acc_r[7:1]};
        cy_nxt = acc_r[0];
        cy_upd = 1'b1;
      end
      default:  res = src_val;
    endcase
  end

  // apb writes win over the core in the same cycle
  always_comb begin
    acc_nxt  = acc_r;
    mulb_nxt = mulb_r;
    psw_nxt  = psw_r;
    dpl_nxt  = dpl_r;
    dph_nxt  = dph_r;
    if (retire) begin
      if (dec.dst == DST_ACC) begin
        acc_nxt = res;
      end
      if (wr_sfr && dst_adr == `MC_SFR_ACC) begin
        acc_nxt = res;
      end
      if (wr_sfr && dst_adr == `MC_SFR_MULB) begin
        mulb_nxt = res;
      end
      if (wr_sfr && dst_adr == `MC_SFR_PSW) begin
        psw_nxt = res;
      end
      if (wr_sfr && dst_adr == `MC_SFR_DPL) begin
        dpl_nxt = res;
      end
      if (wr_sfr && dst_adr == `MC_SFR_DPH) begin
        dph_nxt = res;
      end
      if (dec.dst == DST_DATA_POINTER_16) begin
        dph_nxt = opb1;
        dpl_nxt = opb2;
      end
      if (cy_upd) begin
        psw_nxt[`MC_BIT_CY] = cy_nxt;
      end
    end
    if (acc_wr) begin
      acc_nxt = apb.pwdata[7:0];
    end
    if (mulb_wr) begin
      mulb_nxt = apb.pwdata[7:0];
    end
    if (psw_wr) begin
      psw_nxt = apb.pwdata[7:0];
    end
  end

  // an illegal opcode halts; the halt wins over a run write
  assign run_nxt = bad_op ? 1'b0 :
                   ctrl_wr ? apb.pwdata[`MC_BIT_RUN] : run_r;
  assign ill_nxt = bad_op | (ill_r & ~(ctrl_wr & apb.pwdata[`MC_BIT_ILL]));

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_C0: begin
        if (issue) begin
          st_nxt = last ? ST_C0 : ST_C1;
        end
      end
      ST_C1: begin
        if (issue) begin
          st_nxt = last ? ST_C0 : ST_C2;
        end
      end
      ST_C2: begin
        if (issue) begin
          st_nxt = ST_C0;
        end
      end
      default: st_nxt = ST_C0;
    endcase
    if (pc_wr) begin
      st_nxt = ST_C0;
    end
  end

  // fetch address stays pc plus cycle index, registered for the code port
  always_comb begin
    pc_nxt = pc_r;
    fa_nxt = fa_r;
    if (retire) begin
      pc_nxt = pc_r + {14'h0000, dec.len};
      fa_nxt = pc_r + {14'h0000, dec.len};
    end else if (issue) begin
      fa_nxt = fa_r + 16'h0001;
    end
    if (pc_wr) begin
      pc_nxt = apb.pwdata[15:0];
      fa_nxt = apb.pwdata[15:0];
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    case (apb.paddr)
      `MC_OFF_CTRL: rd_val = {30'h0000_0000, ill_r, run_r};
      `MC_OFF_STAT: rd_val = {15'h0000, ill_r, op_r, 5'h00, st_r};
      `MC_OFF_PC:   rd_val = {16'h0000, pc_r};
      `MC_OFF_DATA_POINTER_16: rd_val = {16'h0000, dph_r, dpl_r};
      `MC_OFF_PSW,
      `MC_OFF_ACC,
      `MC_OFF_MULB: rd_val = {24'h00_0000, sfr_rd(apb.paddr)};
      default:      rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_C0;
      pc_r <= `MC_RST_PC;
      fa_r <= `MC_RST_PC;
    end else begin
      st_r <= st_nxt;
      pc_r <= pc_nxt;
      fa_r <= fa_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_r <= `MC_RST_BYTE;
      b1_r <= `MC_RST_BYTE;
    end else begin
      if (issue && first) begin
        op_r <= code_data;
      end
      if (issue && st_r == ST_C1) begin
        b1_r <= code_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_r  <= `MC_RST_BYTE;
      mulb_r <= `MC_RST_BYTE;
      psw_r  <= `MC_RST_BYTE;
      dpl_r  <= `MC_RST_BYTE;
      dph_r  <= `MC_RST_BYTE;
    end else begin
      acc_r  <= acc_nxt;
      mulb_r <= mulb_nxt;
      psw_r  <= psw_nxt;
      dpl_r  <= dpl_nxt;
      dph_r  <= dph_nxt;
    end
  end

  // read data is caught in the setup phase so it leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_r    <= 1'b0;
      ill_r    <= 1'b0;
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else begin
      run_r <= run_nxt;
      ill_r <= ill_nxt;
      if (apb_set) begin
        prdata_r <= rd_val;
        slverr_r <= ~rd_hit;
      end
    end
  end

  assign prdata    = prdata_r;
  assign pslverr   = slverr_r;
  assign pready    = 1'b1;
  assign code_addr = fa_r;
  assign running   = run_r;
endmodule

/* File: mcit_consts.svh */
// constants of the instruction timing core
// Overview of operation
// - AND/OR/XOR/MOV between working register and accumulator: one byte, one cycle.
// - logic or move from direct byte into accumulator: two bytes, two cycles.
// - logic op from indirect RAM into accumulator: one byte, two cycles.
// - logic or move of immediate into accumulator: two bytes, two cycles.
// - logic or move of accumulator into direct byte: two bytes, two cycles.
// - AND/OR/XOR immediate into direct byte: three bytes, three cycles.
// - clear, complement, rotates and nibble swap of accumulator: one byte, one cycle.
// - working register from direct byte or immediate: two bytes, two cycles.
// - accumulator to or from indirect RAM: one byte, two cycles.
// - direct byte to direct byte: three bytes, three cycles.
// - immediate into direct byte: three bytes, three cycles.
// - indirect RAM to or from direct byte: two bytes, two cycles.
// - immediate into indirect RAM: two bytes, two cycles.
// - data pointer load takes three bytes and updates both halves together.
// - one single-cycle instruction retires every clock at full rate.
`ifndef MCIT_CONSTS_SVH
`define MCIT_CONSTS_SVH
`define MC_OFF_CTRL  8'h00
`define MC_OFF_STAT  8'h04
`define MC_OFF_PC    8'h08
`define MC_OFF_DATA_POINTER_16  8'h0c
`define MC_OFF_PSW   8'hd0
`define MC_OFF_ACC   8'he0
`define MC_OFF_MULB  8'hf0
`define MC_SFR_PSW   8'hd0
`define MC_SFR_ACC   8'he0
`define MC_SFR_MULB  8'hf0
`define MC_SFR_DPL   8'h82
`define MC_SFR_DPH   8'h83
`define MC_RST_BYTE  8'h00
`define MC_RST_PC    16'h0000
`define MC_BIT_RUN   0
`define MC_BIT_ILL   1
`define MC_BIT_CY    7
`define MC_BANK_HI   4
`define MC_BANK_LO   3
`define MC_N1        2'd1
`define MC_N2        2'd2
`define MC_N3        2'd3
`endif

/* File: mcit_pkg.sv */
// shared types of the instruction timing core
package mcit_pkg;
  typedef enum logic [2:0] {
    ST_C0 = 3'b001,
    ST_C1 = 3'b010,
    ST_C2 = 3'b100
  } mcit_state_t;
  typedef enum logic [2:0] {
    SRC_ACC, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM
  } mcit_src_t;
  typedef enum logic [2:0] {
    DST_NONE, DST_ACC, DST_REG, DST_DIR, DST_IND, DST_DATA_POINTER_16
  } mcit_dst_t;
  typedef enum logic [3:0] {
    ALU_MOV, ALU_AND, ALU_OR, ALU_XOR, ALU_CLR, ALU_CPL, ALU_RL,
    ALU_RLC, ALU_RR, ALU_RRC, ALU_SWAP, ALU_NOP
  } mcit_alu_t;
  typedef struct packed {
    logic [1:0] len;
    logic [1:0] cyc;
    mcit_src_t  src;
    mcit_dst_t  dst;
    mcit_alu_t  alu;
    logic       ill;
  } mcit_dec_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } mcit_apb_req_t;
endpackage

/* File: mcit_ram.sv */
// internal data ram, two read ports and one write port
module mcit_ram (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] ra_addr,
  output logic      [7:0] ra_data,
  input  wire logic [7:0] rb_addr,
  output logic      [7:0] rb_data,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata
);
  logic [7:0] mem_r [256];

  assign ra_data = mem_r[ra_addr];
  assign rb_data = mem_r[rb_addr];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (we) begin
      mem_r[waddr] <= wdata;
    end
  end
endmodule

/* File: mcit_decode.sv */
// opcode decoder: byte count, cycle count and datapath selects
`include "mcit_consts.svh"
module mcit_decode (
  input  wire logic [7:0]    op,
  output mcit_pkg::mcit_dec_t dec
);
  import mcit_pkg::*;

  function automatic mcit_dec_t mk(input logic [1:0] n, input logic [1:0] c,
                                   input mcit_src_t s, input mcit_dst_t d,
                                   input mcit_alu_t a);
    return '{len: n, cyc: c, src: s, dst: d, alu: a, ill: 1'b0};
  endfunction

  wire       logic_grp = (op[7:4] == 4'h4) | (op[7:4] == 4'h5)
                       | (op[7:4] == 4'h6);
  mcit_alu_t lg;
  assign lg = op[4] ? ALU_AND : (op[5] ? ALU_XOR : ALU_OR);

  always_comb begin
    dec = mk(`MC_N1, `MC_N1, SRC_ACC, DST_NONE, ALU_NOP);
    dec.ill = 1'b1;
    if (logic_grp) begin
      casez (op[3:0])
        4'h2:    dec = mk(`MC_N2, `MC_N2, SRC_ACC, DST_DIR, lg);
        4'h3:    dec = mk(`MC_N3, `MC_N3, SRC_IMM, DST_DIR, lg);
        4'h4:    dec = mk(`MC_N2, `MC_N2, SRC_IMM, DST_ACC, lg);
        4'h5:    dec = mk(`MC_N2, `MC_N2, SRC_DIR, DST_ACC, lg);
        4'b011?: dec = mk(`MC_N1, `MC_N2, SRC_IND, DST_ACC, lg);
        4'b1???: dec = mk(`MC_N1, `MC_N1, SRC_REG, DST_ACC, lg);
        default: dec.ill = 1'b1;
      endcase
    end else begin
      casez (op)
        8'h00: dec = mk(`MC_N1, `MC_N1, SRC_ACC, DST_NONE, ALU_NOP);
        8'h03: dec = mk(`MC_N1, `MC_N1, SRC_ACC, DST_ACC, ALU_RR);
        8'h13: dec = mk(`MC_N1, `MC_N1, SRC_ACC, DST_ACC, ALU_RRC);
        8'h23: dec = mk(`MC_N1, `MC_N1, SRC_ACC, DST_ACC, ALU_RL);
        8'h33: dec = mk(`MC_N1, `MC_N1, SRC_ACC, DST_ACC, ALU_RLC);
        8'hc4: dec = mk(`MC_N1, `MC_N1, SRC_ACC, DST_ACC, ALU_SWAP);
        8'he4: dec = mk(`MC_N1, `MC_N1, SRC_ACC, DST_ACC, ALU_CLR);
        8'hf4: dec = mk(`MC_N1, `MC_N1, SRC_ACC, DST_ACC, ALU_CPL);
        8'b1110_1???: dec = mk(`MC_N1, `MC_N1, SRC_REG, DST_ACC, ALU_MOV);
        8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff:
          dec = mk(`MC_N1, `MC_N1, SRC_ACC, DST_REG, ALU_MOV);
        8'he5: dec = mk(`MC_N2, `MC_N2, SRC_DIR, DST_ACC, ALU_MOV);
        8'b1110_011?: dec = mk(`MC_N1, `MC_N2, SRC_IND, DST_ACC, ALU_MOV);
        8'h74: dec = mk(`MC_N2, `MC_N2, SRC_IMM, DST_ACC, ALU_MOV);
        8'b1010_1???: dec = mk(`MC_N2, `MC_N2, SRC_DIR, DST_REG, ALU_MOV);
        8'b0111_1???: dec = mk(`MC_N2, `MC_N2, SRC_IMM, DST_REG, ALU_MOV);
        8'hf5: dec = mk(`MC_N2, `MC_N2, SRC_ACC, DST_DIR, ALU_MOV);
        8'b1000_1???: dec = mk(`MC_N2, `MC_N2, SRC_REG, DST_DIR, ALU_MOV);
        8'h85: dec = mk(`MC_N3, `MC_N3, SRC_DIR, DST_DIR, ALU_MOV);
        8'b1000_011?: dec = mk(`MC_N2, `MC_N2, SRC_IND, DST_DIR, ALU_MOV);
        8'h75: dec = mk(`MC_N3, `MC_N3, SRC_IMM, DST_DIR, ALU_MOV);
        8'b1111_011?: dec = mk(`MC_N1, `MC_N2, SRC_ACC, DST_IND, ALU_MOV);
        8'b1010_011?: dec = mk(`MC_N2, `MC_N2, SRC_DIR, DST_IND, ALU_MOV);
        8'b0111_011?: dec = mk(`MC_N2, `MC_N2, SRC_IMM, DST_IND, ALU_MOV);
        8'h90: dec = mk(`MC_N3, `MC_N3, SRC_IMM, DST_DATA_POINTER_16, ALU_MOV);
        default: dec.ill = 1'b1;
      endcase
    end
  end
endmodule

/* File: mcit_code_rom.sv */
// program memory model answering the core's code fetch port
module mcit_code_rom (
  input  wire logic [15:0] code_addr,
  output logic      [7:0]  code_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];
  // unloaded bytes hold an unsupported opcode so a stray fetch halts
  initial begin
    foreach (mem[i]) mem[i] = 8'ha5;
  end
  // asynchronous read, valid in the cycle of the address
  assign code_data = mem[code_addr];
endmodule

/* File: mcit_asserts.sv */
// port assertions for the instruction timing core
module mcit_asserts
  import mcit_pkg::*;
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire mcit_pkg::mcit_apb_req_t apb,
  input wire logic             [31:0] prdata,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire logic             [15:0] code_addr,
  input wire logic             [7:0]  code_data,
  input wire logic                    running
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc_ph = apb.psel && apb.penable;
  wire ctrl_wr = acc_ph && apb.pwrite && apb.paddr == 8'h00;
  wire pc_wr = acc_ph && apb.pwrite && apb.paddr == 8'h08;
  wire mapped = apb.paddr inside {8'h00, 8'h04, 8'h08, 8'h0c,
                                  8'hd0, 8'he0, 8'hf0};
  sequence s_run2;
    running ##1 running;
  endsequence
  sequence s_halt2;
    (!running && !pc_wr) ##1 !running;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0)
    !presetn |-> code_addr == 16'h0000 && !running && !pslverr)
    else $error("outputs not quiet in reset");
  a_halt_addr: assert property (s_halt2 |-> $stable(code_addr))
    else $error("code address moved while halted");
  a_addr_step: assert property (s_run2 |->
    code_addr == $past(code_addr) || code_addr == $past(code_addr) + 16'h1)
    else $error("code address jumped while running");
  a_hold_once: assert property (
    running && $past(running) && $stable(code_addr) ##1 running
    |-> !$stable(code_addr))
    else $error("code address held too long");
  a_err_decode: assert property (acc_ph |-> pslverr == !mapped)
    else $error("slave error does not match address map");
  a_upper_zero: assert property (acc_ph && !apb.pwrite &&
    apb.paddr inside {8'hd0, 8'he0, 8'hf0} |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_run_cause: assert property ($rose(running) |->
    $past(ctrl_wr && apb.pwdata[0]))
    else $error("core started without a run write");
  a_run_stop: assert property (ctrl_wr && !apb.pwdata[0] |=> !running)
    else $error("core kept running after stop write");
endmodule
bind mcit_core mcit_asserts mcit_asserts_inst (
  .pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .code_addr(code_addr),
  .code_data(code_data), .running(running));

/* File: testbench.sv */
// self-checking bench for the instruction timing core
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mcit_pkg::*;
  logic          pclk;
  logic          presetn;
  mcit_apb_req_t apb;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic [15:0]   code_addr;
  logic [7:0]    code_data;
  logic          running;
  int            fail_count;
  int            total_checks;
  int            run_cycles;
  int            pa;
  int            t [2];
  logic [31:0]   rd;
  logic [31:0]   rv;
  logic          err;
  logic [7:0]    op, a, b, v, p, m, h, l;
  logic [1:0]    ln, cy;
  logic          c;
  logic [8:0]    e;
  // opcode, byte count, cycle count
  logic [11:0] tbl [0:39] = '{12'h485, 12'h6a5, 12'he95, 12'hfb5,
    12'h45a, 12'h65a, 12'he5a, 12'h55a, 12'h466, 12'h676, 12'h566,
    12'h44a, 12'h64a, 12'h74a, 12'h54a, 12'h42a, 12'h62a, 12'h52a,
    12'hf5a, 12'h43f, 12'h63f, 12'h53f, 12'he45, 12'hf45, 12'h235,
    12'h335, 12'h035, 12'h135, 12'hc45, 12'ha8a, 12'h7fa, 12'he66,
    12'hf76, 12'h85f, 12'h75f, 12'h86a, 12'ha7a, 12'h76a, 12'h90f,
    12'h005};
  logic [7:0] regs [0:5] = '{8'h00, 8'h08, 8'h0c, 8'hd0, 8'he0, 8'hf0};

  mcit_core mcit_core_inst (
    .pclk     (pclk),
    .presetn  (presetn),
    .apb      (apb),
    .prdata   (prdata),
    .pready   (pready),
    .pslverr  (pslverr),
    .code_addr(code_addr),
    .code_data(code_data),
    .running  (running)
  );
  mcit_code_rom mcit_code_rom_inst (
    .code_addr(code_addr),
    .code_data(code_data)
  );

  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    if (running === 1'b1) run_cycles <= run_cycles + 1;
  end

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_time(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one idle edge first so psel is never assigned twice in a step
  task automatic xfer(input logic w, input logic [7:0] ad,
                      input logic [31:0] wd);
    int n;
    @(posedge pclk);
    apb.psel <= 1'b1;
    apb.penable <= 1'b0;
    apb.pwrite <= w;
    apb.paddr <= ad;
    apb.pwdata <= wd;
    @(posedge pclk);
    apb.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      results();
    end
    rd = prdata;
    err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp);
    xfer(1'b0, ad, 32'h0);
    chk_reg(rd, exp);
  endtask
  task automatic emit(input logic [7:0] bt);
    mcit_code_rom_inst.mem[pa] = bt;
    pa++;
  endtask
  // halted runs only: pc load then start, wait for the illegal stop
  task automatic run_prog(output int cnt);
    int n;
    xfer(1'b1, 8'h08, 32'h0);
    run_cycles = 0;
    xfer(1'b1, 8'h00, 32'h1);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (running !== 1'b0 && n < 200);
    if (running !== 1'b0) begin
      fail_count++;
      results();
    end
    cnt = run_cycles;
  endtask
  function automatic logic [8:0] acc_fn(input logic [7:0] o,
      input logic [7:0] x, input logic [7:0] y, input logic k);
    case (o)
      8'he4: return {k, 8'h00};
      8'hf4: return {k, ~x};
      8'h23: return {k, x[6:0], x[7]};
      8'h33: return {x, k};
      8'h03: return {k, x[0], x[7:1]};
      8'h13: return {x[0], k, x[7:1]};
      8'hc4: return {k, x[3:0], x[7:4]};
      8'h44: return {k, x | y};
      8'h64: return {k, x ^ y};
      8'h74: return {k, y};
      default: return {k, x & y};
    endcase
  endfunction

  initial begin
    pclk = 1'b0;
    // start high so the falling edge resets every flop
    presetn = 1'b1;
    apb = '0;
    fail_count = 0;
    total_checks = 0;
    run_cycles = 0;
    void'($urandom(90));
    #1 presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 32'h0);
    xfer(1'b0, 8'h10, 32'h0);
    chk_reg({31'h0, err}, 32'h1);
    xfer(1'b1, 8'he1, 32'hff);
    chk_reg({31'h0, err}, 32'h1);
    rdchk(8'he0, 32'h0);
    xfer(1'b1, 8'h00, 32'h0);
    rv = $urandom;
    xfer(1'b1, 8'hf0, rv);
    rdchk(8'hf0, {24'h0, rv[7:0]});
    xfer(1'b1, 8'h08, rv);
    rdchk(8'h08, {16'h0, rv[15:0]});
    // timing: four copies against one isolates the cycle count
    foreach (tbl[i]) begin
      {op, ln, cy} = tbl[i];
      for (int r = 0; r < 2; r++) begin
        pa = 0;
        for (int k = 0; k < 1 + 3 * r; k++) begin
          emit(op);
          for (int j = 1; j < ln; j++) emit(8'($urandom));
        end
        emit(8'ha5);
        run_prog(t[r]);
        rdchk(8'h08, 32'(pa - 1));
      end
      chk_time(t[1] - t[0], 3 * int'(cy));
    end
    for (int i = 22; i < 32; i++) begin
      {op, ln, cy} = (i < 29) ? tbl[i] : tbl[i - 18];
      {a, b, c} = 17'($urandom);
      xfer(1'b1, 8'hd0, {24'h0, c, 7'h0});
      pa = 0;
      emit(8'h74);
      emit(a);
      emit(op);
      if (ln == 2'd2) emit(b);
      emit(8'ha5);
      run_prog(t[0]);
      e = acc_fn(op, a, b, c);
      rdchk(8'he0, {24'h0, e[7:0]});
      rdchk(8'hd0, {24'h0, e[8], 6'h0, ^e[7:0]});
    end
    {v, a, m, h, l} = 40'({$urandom, $urandom});
    p = {1'b1, 7'($urandom)};
    pa = 0;
    foreach (regs[i]) emit(8'h00);
    pa = 0;
    emit(8'h75); emit(8'h40); emit(v);
    emit(8'h74); emit(a);
    emit(8'h62); emit(8'h40);
    emit(8'h78); emit(p);
    emit(8'ha6); emit(8'h40);
    emit(8'he6);
    emit(8'h85); emit(8'h40); emit(8'h41);
    emit(8'h53); emit(8'h41); emit(m);
    emit(8'he5); emit(8'h41);
    emit(8'h90); emit(h); emit(l);
    emit(8'ha5);
    run_prog(t[0]);
    rdchk(8'he0, {24'h0, (v ^ a) & m});
    rdchk(8'h0c, {16'h0, h, l});
    rdchk(8'h04, 32'h0001_9001);
    rdchk(8'h00, 32'h0000_0002);
    xfer(1'b1, 8'h00, 32'h0000_0002);
    rdchk(8'h00, 32'h0000_0000);
    results();
  end
endmodule
